/* File: hw/dram_timing_pkg.sv */
package dram_timing_pkg;

   // One-hot access sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_ACCESS  = 3'b010,
      ST_REFRESH = 3'b100
   } seq_state_t;

   // Width of the shared row-strobe interval counter.
   localparam int unsigned TMR_W = 3;

   // Handshake style values.
   localparam logic HS_WAIT = 1'b0;
   localparam logic HS_ACK  = 1'b1;

   // Burst handshake codes.
   localparam logic [1:0] BURST_NONE = 2'b00;
   localparam logic [1:0] BURST_HALF = 2'b10;

   // Reset values of the programmed settings.
   localparam logic [1:0] CODE_RST = 2'h0;
   localparam logic       BIT_RST  = 1'b0;

   // Row strobe low time during refresh, in rising clock edges.
   function automatic logic [TMR_W-1:0] refresh_low(input logic [1:0] c);
      unique case (c)
         2'b00:   refresh_low = 3'h2;
         2'b01:   refresh_low = 3'h3;
         2'b10:   refresh_low = 3'h2;
         2'b11:   refresh_low = 3'h4;
      endcase
   endfunction

   // Row strobe precharge time, in rising clock edges.
   function automatic logic [TMR_W-1:0] precharge(input logic [1:0] c);
      unique case (c)
         2'b00:   precharge = 3'h1;
         2'b01:   precharge = 3'h2;
         2'b10:   precharge = 3'h2;
         2'b11:   precharge = 3'h3;
      endcase
   endfunction

   // Delay from the access row strobe to the first release, in half
   // clock periods; bit 0 set means the release lands on a low phase.
   function automatic logic [2:0] release_halves(input logic       ack,
                                                 input logic [1:0] c,
                                                 input logic       dly);
      if (ack) begin
         unique case (c)
            2'b00:   release_halves = 3'h0;
            2'b01:   release_halves = 3'h2;
            2'b10:   release_halves = 3'h1;
            2'b11:   release_halves = 3'h3;
         endcase
      end else begin
         unique case (c)
            2'b00:   release_halves = 3'h0;
            2'b01:   release_halves = 3'h1;
            2'b10:   release_halves = dly ? 3'h1 : 3'h0;
            2'b11:   release_halves = 3'h2;
         endcase
      end
   endfunction

endpackage

/* File: hw/strobe_timer.sv */
// Down counter that times row strobe low and precharge intervals.
module strobe_timer
   import dram_timing_pkg::*;
(
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic             i_load,
   input  wire logic [TMR_W-1:0] i_value,
   output logic                  o_zero
);

   logic [TMR_W-1:0] cnt_r;   // Edges left in the interval.
   logic [TMR_W-1:0] cnt_nxt; // Next count.

   // A load wins over the running count; otherwise count down to zero.
   always_comb begin
      cnt_nxt = cnt_r;
      if (i_load) begin
         cnt_nxt = i_value;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 3'h1;
      end
   end

   // Count register; zero after reset so the first access is not held.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign o_zero = (cnt_r == '0);

endmodule

/* File: hw/dram_access_wait_timing.sv */
module dram_access_wait_timing
   import dram_timing_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       i_program,
   input  wire logic       i_mode_select_bit,
   input  wire logic       i_handshake_type_bit,
   input  wire logic [1:0] i_burst_handshake_code,
   input  wire logic [1:0] i_first_access_delay_code,
   input  wire logic [1:0] i_row_strobe_timing_code,
   input  wire logic       i_addr_strobe,
   input  wire logic       i_chip_select_n,
   input  wire logic       i_access_hold_req_n,
   input  wire logic       i_column_enable_in_n,
   input  wire logic       i_refresh_req,
   input  wire logic       i_second_port_granted,
   output logic            o_row_strobe_n,
   output logic            o_wait_n,
   output logic            o_transfer_ack_n,
   output logic            o_refresh_active,
   output logic            o_mode_async
);

   logic rst_meta_r; // First reset release stage.
   logic rst_n;      // Released reset used by the whole block.

   // Reset is applied at once but released through two flops.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Programmed settings.
   logic       hs_type_r,    hs_type_nxt;    // Acknowledge style when set.
   logic       async_r,      async_nxt;      // Asynchronous start mode.
   logic [1:0] burst_code_r, burst_code_nxt; // Burst handshake code.
   logic [1:0] delay_code_r, delay_code_nxt; // First access delay code.
   logic [1:0] rs_code_r,    rs_code_nxt;    // Row strobe timing code.

   // Settings move only on a programming pulse.
   always_comb begin
      hs_type_nxt    = hs_type_r;
      async_nxt      = async_r;
      burst_code_nxt = burst_code_r;
      delay_code_nxt = delay_code_r;
      rs_code_nxt    = rs_code_r;
      if (i_program) begin
         hs_type_nxt    = i_handshake_type_bit;
         async_nxt      = i_mode_select_bit;
         burst_code_nxt = i_burst_handshake_code;
         delay_code_nxt = i_first_access_delay_code;
         rs_code_nxt    = i_row_strobe_timing_code;
      end
   end

   // Settings registers.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         hs_type_r    <= BIT_RST;
         async_r      <= BIT_RST;
         burst_code_r <= CODE_RST;
         delay_code_r <= CODE_RST;
         rs_code_r    <= CODE_RST;
      end else begin
         hs_type_r    <= hs_type_nxt;
         async_r      <= async_nxt;
         burst_code_r <= burst_code_nxt;
         delay_code_r <= delay_code_nxt;
         rs_code_r    <= rs_code_nxt;
      end
   end

   // Sequencer state.
   seq_state_t state_r,     state_nxt;     // Access, refresh or idle.
   logic       ras_n_r,     ras_n_nxt;     // Row strobe, active low.
   logic       ready_r,     ready_nxt;     // Handshake released.
   logic       half_r,      half_nxt;      // Release waits for low phase.
   logic       first_r,     first_nxt;     // First release already given.
   logic [1:0] rel_cnt_r,   rel_cnt_nxt;   // Edges left before release.
   logic       pend_r,      pend_nxt;      // Request waiting to start.
   logic       strobe_q_r;                 // Address strobe, last edge.
   logic       grant_q_r;                  // Second port grant, last edge.
   logic       ready_neg_r;                // Ready seen at the low phase.
   logic       req;                        // Start request this edge.
   logic       clear;                      // Nothing blocks a row strobe.
   logic       tmr_zero;                   // Interval counter expired.
   logic       tmr_load;                   // Reload the interval counter.
   logic [TMR_W-1:0] tmr_value;            // Interval reload value.
   logic [2:0] rel;                        // First release in halves.
   logic tmp_zero_w; // Expiry flag from the interval counter.

   strobe_timer u_timer (
      .i_mclk  (i_mclk),
      .i_rst_n (rst_n),
      .i_load  (tmr_load),
      .i_value (tmr_value),
      .o_zero  (tmp_zero_w)
   );
   assign tmr_zero = tmp_zero_w;

   // Next values of the sequencer. Accesses take priority over refresh
   // when both are ready in the same cycle; refresh waits its turn.
   always_comb begin
      state_nxt   = state_r;
      ras_n_nxt   = ras_n_r;
      ready_nxt   = ready_r;
      half_nxt    = half_r;
      first_nxt   = first_r;
      rel_cnt_nxt = rel_cnt_r;
      pend_nxt    = pend_r;
      tmr_load    = 1'b0;
      tmr_value   = '0;
      // Asynchronous mode needs a fresh strobe for every access.
      req = (async_r ? (i_addr_strobe && !strobe_q_r)
                     : i_addr_strobe) && !i_chip_select_n;
      // Codes with bit 0 set add one edge after the grant drops.
      clear = tmr_zero && !i_second_port_granted
              && !(grant_q_r && rs_code_r[0]);
      rel = release_halves(hs_type_r, delay_code_r, pend_r);
      unique case (state_r)
         ST_IDLE: begin
            ready_nxt = (hs_type_r == HS_WAIT);
            half_nxt  = 1'b0;
            if ((req || pend_r) && clear) begin
               state_nxt   = ST_ACCESS;
               ras_n_nxt   = 1'b0;
               pend_nxt    = 1'b0;
               half_nxt    = rel[0];
               rel_cnt_nxt = rel[2:1];
               first_nxt   = (rel[2:1] == 2'h0);
               ready_nxt   = (rel[2:1] == 2'h0);
            end else if (req || pend_r) begin
               // Held off: the request is remembered and ready is cleared.
               pend_nxt  = 1'b1;
               ready_nxt = 1'b0;
            end else if (i_refresh_req && tmr_zero
                         && !i_second_port_granted) begin
               state_nxt = ST_REFRESH;
               ras_n_nxt = 1'b0;
               tmr_load  = 1'b1;
               tmr_value = refresh_low(rs_code_r) - 3'h1;
            end
         end
         ST_ACCESS: begin
            if (first_r && i_access_hold_req_n) begin
               state_nxt = ST_IDLE;
               ras_n_nxt = 1'b1;
               first_nxt = 1'b0;
               half_nxt  = 1'b0;
               ready_nxt = (hs_type_r == HS_WAIT);
               tmr_load  = 1'b1;
               tmr_value = precharge(rs_code_r) - 3'h1;
            end else if (!first_r) begin
               if (rel_cnt_r == 2'h1) begin
                  ready_nxt = 1'b1;
                  first_nxt = 1'b1;
               end
               rel_cnt_nxt = rel_cnt_r - 2'h1;
            end else if (burst_code_r != BURST_NONE
                         && !i_access_hold_req_n) begin
               if (i_column_enable_in_n) begin
                  ready_nxt = 1'b0;
               end else if (!ready_r) begin
                  ready_nxt = 1'b1;
                  half_nxt  = (burst_code_r == BURST_HALF);
               end
            end
         end
         ST_REFRESH: begin
            if (tmr_zero) begin
               state_nxt = ST_IDLE;
               ras_n_nxt = 1'b1;
               tmr_load  = 1'b1;
               tmr_value = precharge(rs_code_r) - 3'h1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            ras_n_nxt = 1'b1;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= ST_IDLE;
         ras_n_r    <= 1'b1;
         ready_r    <= 1'b1;
         half_r     <= 1'b0;
         first_r    <= 1'b0;
         rel_cnt_r  <= 2'h0;
         pend_r     <= 1'b0;
         strobe_q_r <= 1'b0;
         grant_q_r  <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         ras_n_r    <= ras_n_nxt;
         ready_r    <= ready_nxt;
         half_r     <= half_nxt;
         first_r    <= first_nxt;
         rel_cnt_r  <= rel_cnt_nxt;
         pend_r     <= pend_nxt;
         strobe_q_r <= i_addr_strobe;
         grant_q_r  <= i_second_port_granted;
      end
   end

   // Low-phase copy of ready; it lets a release land half a cycle
   // after the rising edge that decided it, while a drop stays prompt.
   // It only counts while the row strobe is low: in wait style ready is
   // already high when idle, and without this gate a half-cycle first
   // release would show at the start edge instead of the low phase.
   always_ff @(negedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         ready_neg_r <= 1'b1;
      end else begin
         ready_neg_r <= ready_r && !ras_n_r;
      end
   end

   logic ready_out; // Handshake released as seen on the pins.
   assign ready_out = half_r ? (ready_r && ready_neg_r) : ready_r;

   // Handshake pins follow the programmed style.
   assign o_wait_n         = hs_type_r || ready_out;
   assign o_transfer_ack_n = !(hs_type_r && ready_out);
   assign o_row_strobe_n   = ras_n_r;
   assign o_refresh_active = (state_r == ST_REFRESH);
   assign o_mode_async     = async_r;

   // Checking helpers: edges the row strobe has been low or high.
   logic [2:0] lo_cnt_r;
   logic [2:0] hi_cnt_r;
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         lo_cnt_r <= 3'h0;
         hi_cnt_r <= 3'h7;
      end else begin
         lo_cnt_r <= ras_n_r ? 3'h0 : lo_cnt_r + 3'h1;
         hi_cnt_r <= !ras_n_r ? 3'h0
                   : (hi_cnt_r == 3'h7 ? hi_cnt_r : hi_cnt_r + 3'h1);
      end
   end

   sequence s_access_start;
      $fell(ras_n_r) && state_r == ST_ACCESS;
   endsequence

   property p_refresh_low;
      @(posedge i_mclk) disable iff (!rst_n)
      $rose(ras_n_r) && $past(state_r) == ST_REFRESH
      |-> lo_cnt_r == refresh_low(rs_code_r);
   endproperty
   a_refresh_low: assert property (p_refresh_low)
      else $error("Refresh row strobe low time is wrong.");

   property p_precharge;
      @(posedge i_mclk) disable iff (!rst_n)
      $fell(ras_n_r) |-> hi_cnt_r >= precharge(rs_code_r);
   endproperty
   a_precharge: assert property (p_precharge)
      else $error("Row strobe precharge time was cut short.");

   property p_cfg_hold;
      @(posedge i_mclk) disable iff (!rst_n)
      !i_program |=> $stable({hs_type_r, async_r, burst_code_r,
                              delay_code_r, rs_code_r});
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("Settings changed without programming.");

   property p_sync_start;
      @(posedge i_mclk) disable iff (!rst_n)
      state_r == ST_IDLE && !async_r && req && clear |=> !ras_n_r;
   endproperty
   a_sync_start: assert property (p_sync_start)
      else $error("Row strobe missed the first edge.");

   property p_blocked;
      @(posedge i_mclk) disable iff (!rst_n)
      state_r == ST_IDLE && (req || pend_r) && !clear |=> ras_n_r && pend_r;
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("Blocked access started or was lost.");

   property p_end;
      @(posedge i_mclk) disable iff (!rst_n)
      state_r == ST_ACCESS && first_r && i_access_hold_req_n
      |=> ras_n_r && state_r == ST_IDLE;
   endproperty
   a_end: assert property (p_end)
      else $error("Access did not end on negated hold request.");

   property p_burst_none;
      @(posedge i_mclk) disable iff (!rst_n)
      state_r == ST_ACCESS && first_r && burst_code_r == BURST_NONE
      && !i_access_hold_req_n |=> ready_r;
   endproperty
   a_burst_none: assert property (p_burst_none)
      else $error("Burst wait inserted with burst code zero.");

   property p_burst_gap;
      @(posedge i_mclk) disable iff (!rst_n)
      state_r == ST_ACCESS && first_r && burst_code_r != BURST_NONE
      && !i_access_hold_req_n && i_column_enable_in_n |=> !ready_out;
   endproperty
   a_burst_gap: assert property (p_burst_gap)
      else $error("Column gap did not hold off the handshake.");

   property p_ack_one;
      @(posedge i_mclk) disable iff (!rst_n)
      s_access_start ##0 hs_type_r && delay_code_r == 2'b01
      |-> !ready_r ##1 ready_r;
   endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("Acknowledge not one edge after row strobe.");

   property p_grant;
      @(posedge i_mclk) disable iff (!rst_n)
      state_r == ST_IDLE && grant_q_r && !i_second_port_granted
      && rs_code_r[0] |=> ras_n_r;
   endproperty
   a_grant: assert property (p_grant)
      else $error("Row strobe started on first edge after grant.");

endmodule

/* File: tb/bus_master_model.sv */
// Behavioural processor bus master on the host side of the timing core.
module bus_master_model (
   input  wire logic i_mclk,
   output logic      o_addr_strobe,
   output logic      o_chip_select_n,
   output logic      o_access_hold_req_n,
   output logic      o_column_enable_in_n
);
   timeunit 1ns;
   timeprecision 1ns;

   // Lines start idle, with the column enables asserted.
   initial begin
      o_addr_strobe        = 1'h0;
      o_chip_select_n      = 1'h1;
      o_access_hold_req_n  = 1'h1;
      o_column_enable_in_n = 1'h0;
   end

   // Start an access just after an edge, so it is sampled cleanly.
   task automatic request();
      @(posedge i_mclk);
      o_addr_strobe   <= 1'h1;
      o_chip_select_n <= 1'h0;
   endtask

   // Hold the access after d edges; a large d plays a slow master.
   // Strobe and select are let go at once, as early as allowed.
   task automatic hold(input int d);
      repeat (d) @(posedge i_mclk);
      o_access_hold_req_n <= 1'h0;
      o_addr_strobe       <= 1'h0;
      o_chip_select_n     <= 1'h1;
   endtask

   // End the access; optionally ask again at the very edge where the
   // end is sampled, which probes the precharge spacing.
   task automatic finish(input bit again);
      @(posedge i_mclk);
      o_access_hold_req_n <= 1'h1;
      @(posedge i_mclk);
      if (again) begin
         o_addr_strobe   <= 1'h1;
         o_chip_select_n <= 1'h0;
      end
   endtask

   // Move the column enables, for burst gaps.
   task automatic col(input logic v);
      @(posedge i_mclk);
      o_column_enable_in_n <= v;
   endtask
endmodule

/* File: tb/test_dram_access_wait_timing.sv */
// Self-checking bench of the access timing core.
module test_dram_access_wait_timing;
   timeunit 1ns;
   timeprecision 1ns;

   // Count one comparison and report a mismatch at once.
   `define CHECK(nm, e, a) \
      begin \
         num_checks++; \
         if ((a) !== (e)) begin \
            fail_count++; \
            $display("unexpected %s: expected %0h seen %0h", nm, e, a); \
         end \
      end

   // One access case: style, delay code, timing code, release in halves.
   typedef struct {
      logic       hs;
      logic [1:0] dly;
      logic [1:0] rs;
      int         h;
   } row_t;

   logic       mclk;
   logic       rst_n;
   logic       prog_en;
   logic       mode;
   logic       hs;
   logic [1:0] burst;
   logic [1:0] dly;
   logic [1:0] rs;
   logic       refresh_req;
   logic       granted;
   logic       strobe;
   logic       cs_n;
   logic       hold_n;
   logic       ce_n;
   logic       rs_n;
   logic       wait_n;
   logic       ack_n;
   logic       refr;
   logic       mode_async;
   int         fail_count = 0;
   int         num_checks = 0;
   int         n;
   int         pre [4]    = '{1, 2, 2, 3};
   int         rlow [4]   = '{2, 3, 2, 4};
   row_t       rows [8]   = '{'{1'h0, 2'h0, 2'h0, 0},
                              '{1'h0, 2'h1, 2'h1, 1},
                              '{1'h0, 2'h2, 2'h2, 0},
                              '{1'h0, 2'h3, 2'h3, 2},
                              '{1'h1, 2'h0, 2'h0, 0},
                              '{1'h1, 2'h1, 2'h1, 2},
                              '{1'h1, 2'h2, 2'h2, 1},
                              '{1'h1, 2'h3, 2'h3, 3}};

   dram_access_wait_timing i_dram_access_wait_timing (
      .i_mclk                    (mclk),
      .i_rst_n                   (rst_n),
      .i_program                 (prog_en),
      .i_mode_select_bit         (mode),
      .i_handshake_type_bit      (hs),
      .i_burst_handshake_code    (burst),
      .i_first_access_delay_code (dly),
      .i_row_strobe_timing_code  (rs),
      .i_addr_strobe             (strobe),
      .i_chip_select_n           (cs_n),
      .i_access_hold_req_n       (hold_n),
      .i_column_enable_in_n      (ce_n),
      .i_refresh_req             (refresh_req),
      .i_second_port_granted     (granted),
      .o_row_strobe_n            (rs_n),
      .o_wait_n                  (wait_n),
      .o_transfer_ack_n          (ack_n),
      .o_refresh_active          (refr),
      .o_mode_async              (mode_async)
   );

   bus_master_model i_bus_master_model (
      .i_mclk               (mclk),
      .o_addr_strobe        (strobe),
      .o_chip_select_n      (cs_n),
      .o_access_hold_req_n  (hold_n),
      .o_column_enable_in_n (ce_n)
   );

   // Free-running 10 MHz clock.
   always #50 mclk = ~mclk;

   // Print the counts and the verdict, then end the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Load all settings with one program pulse.
   task automatic prog(input logic m, input logic h, input logic [1:0] b,
                       input logic [1:0] d, input logic [1:0] r);
      @(posedge mclk);
      prog_en <= 1'h1;
      mode    <= m;
      hs      <= h;
      burst   <= b;
      dly     <= d;
      rs      <= r;
      @(posedge mclk);
      prog_en <= 1'h0;
      #10;
   endtask

   // Count edges until the row strobe reaches v; a hang ends the run.
   task automatic wait_rs(input logic v, output int cnt);
      cnt = 0;
      do begin
         @(posedge mclk);
         #10;
         cnt++;
      end while (rs_n !== v && cnt < 20);
      if (rs_n !== v) begin
         fail_count++;
         $display("unexpected row strobe timeout: expected %0h", v);
         stop_test();
      end
   endtask

   // True once the handshake of the given style has let the master go.
   function automatic logic done_now(input logic h);
      return h ? ~ack_n : wait_n;
   endfunction

   // Full access with release timing; optionally a back-to-back one.
   task automatic access(input row_t r, input bit again);
      int cnt;
      // The hold request goes low at the start edge, so it is sampled
      // from the first edge on which the release can be seen.
      i_bus_master_model.request();
      fork
         wait_rs(1'h0, cnt);
         i_bus_master_model.hold(1);
      join
      `CHECK("start edges", 1, cnt)
      if (r.h > 0) begin
         #((r.h - 1) * 50);
         `CHECK("early release", 1'h0, done_now(r.hs))
         #50;
      end
      `CHECK("release", 1'h1, done_now(r.hs))
      `CHECK("other style", 1'h1, r.hs ? wait_n : ack_n)
      i_bus_master_model.finish(again);
      #10;
      `CHECK("end row strobe", 1'h1, rs_n)
      `CHECK("end ack", 1'h1, ack_n)
      if (again) begin
         fork
            wait_rs(1'h0, cnt);
            i_bus_master_model.hold(pre[r.rs]);
         join
         `CHECK("precharge", pre[r.rs], cnt)
         i_bus_master_model.finish(1'b0);
      end
   endtask

   initial begin
      mclk        = 1'h0;
      rst_n       = 1'h0;
      prog_en     = 1'h0;
      mode        = 1'h0;
      hs          = 1'h0;
      burst       = 2'h0;
      dly         = 2'h0;
      rs          = 2'h0;
      refresh_req = 1'h0;
      granted     = 1'h0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'h1;
      #10;
      `CHECK("reset row strobe", 1'h1, rs_n)
      `CHECK("reset wait", 1'h1, wait_n)
      `CHECK("reset ack", 1'h1, ack_n)
      `CHECK("reset refresh", 1'h0, refr)
      repeat (4) @(posedge mclk);
      // Every style and delay code, each followed by a restart.
      foreach (rows[i]) begin
         prog(1'h0, rows[i].hs, 2'h0, rows[i].dly, rows[i].rs);
         `CHECK("sync mode", 1'h0, mode_async)
         access(rows[i], 1'b1);
         repeat (5) @(posedge mclk);
      end
      // Refresh low time for every timing code.
      for (int c = 0; c < 4; c++) begin
         prog(1'h0, 1'h1, 2'h0, 2'h0, c[1:0]);
         @(posedge mclk) refresh_req <= 1'h1;
         wait_rs(1'h0, n);
         `CHECK("refresh flag", 1'h1, refr)
         wait_rs(1'h1, n);
         `CHECK("refresh low", rlow[c], n)
         @(posedge mclk);
         refresh_req <= 1'h0;
         repeat (12) @(posedge mclk);
      end
      // A request blocked by the other port is delayed past the grant.
      for (int c = 0; c < 2; c++) begin
         prog(1'h0, 1'h0, 2'h0, 2'h2, {1'h0, c[0]});
         @(posedge mclk) granted <= 1'h1;
         i_bus_master_model.request();
         repeat (3) @(posedge mclk);
         #10;
         `CHECK("blocked row strobe", 1'h1, rs_n)
         `CHECK("blocked wait", 1'h0, wait_n)
         @(posedge mclk);
         granted <= 1'h0;
         wait_rs(1'h0, n);
         `CHECK("grant edges", c + 1, n)
         `CHECK("delayed wait", 1'h0, wait_n)
         #50;
         `CHECK("delayed release", 1'h1, wait_n)
         i_bus_master_model.hold(1);
         i_bus_master_model.finish(1'b0);
         repeat (5) @(posedge mclk);
      end
      // A column gap inside a burst, every burst code.
      for (int b = 0; b < 4; b++) begin
         prog(1'h0, 1'h1, b[1:0], 2'h0, 2'h0);
         i_bus_master_model.request();
         fork
            wait_rs(1'h0, n);
            i_bus_master_model.hold(1);
         join
         i_bus_master_model.col(1'h1);
         @(posedge mclk);
         #10;
         `CHECK("burst gap", b == 0 ? 1'h0 : 1'h1, ack_n)
         i_bus_master_model.col(1'h0);
         @(posedge mclk);
         #10;
         `CHECK("burst back", b == 2 ? 1'h1 : 1'h0, ack_n)
         #50;
         `CHECK("burst half", 1'h0, ack_n)
         i_bus_master_model.finish(1'b0);
         repeat (5) @(posedge mclk);
      end
      // Asynchronous start; settings must hold while not programming.
      prog(1'h1, 1'h1, 2'h0, 2'h1, 2'h0);
      `CHECK("async mode", 1'h1, mode_async)
      @(posedge mclk) mode <= 1'h0;
      hs   <= 1'h0;
      dly  <= 2'h3;
      repeat (2) @(posedge mclk);
      #10;
      `CHECK("held mode", 1'h1, mode_async)
      access(row_t'{1'h1, 2'h1, 2'h0, 2}, 1'b0);
      repeat (5) @(posedge mclk);
      // Reset in mid-access drops everything at once.
      i_bus_master_model.request();
      wait_rs(1'h0, n);
      @(posedge mclk);
      rst_n <= 1'h0;
      #10;
      `CHECK("mid reset strobe", 1'h1, rs_n)
      `CHECK("mid reset mode", 1'h0, mode_async)
      stop_test();
   end
endmodule
